// ### src/wait_ctl_pkg.sv
// shared constants and types for the area wait state controller
package wait_ctl_pkg;
    localparam int num_areas = 8;
    localparam logic [1:0] reg_read_wait = 2'h0;
    localparam logic [1:0] reg_dma_wait = 2'h1;
    localparam logic [1:0] reg_long_wait = 2'h2;
    localparam logic [1:0] reg_bus_ctl = 2'h3;
    localparam logic [15:0] read_wait_reset = 16'hffff;
    localparam logic [15:0] dma_wait_reset = 16'hffff;
    localparam logic [15:0] read_wait_fixed_ones = 16'h00fd;
    localparam logic [15:0] read_wait_writable = 16'hff02;
    localparam logic [3:0] long_wait_reset = 4'hf;
    localparam int rw_msb = 15;
    localparam int rw_lsb = 8;
    localparam int ww1_bit = 1;
    localparam int a02_lw_lsb = 13;
    localparam int a6_lw_lsb = 11;
    localparam int dram_en_bit = 15;
    localparam int mux_io_bit = 14;
    localparam logic [2:0] st_one = 3'h1;
    localparam logic [2:0] st_two = 3'h2;
    localparam logic [2:0] st_three = 3'h3;
    localparam logic [2:0] st_four = 3'h4;

    typedef enum logic [2:0] {
        acc_cpu_read = 3'h0,
        acc_dram_write = 3'h1,
        acc_dma_read = 3'h2,
        acc_dma_write = 3'h3,
        acc_refresh = 3'h4
    } access_kind_t;

    typedef struct packed {
        logic start;
        access_kind_t kind;
        logic [2:0] area;
        logic on_chip;
        logic [1:0] refresh_wait;
    } cycle_req_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage

// ### src/cycle_timer.sv
// counts the states of one bus cycle and samples the wait input
`timescale 1ns/100ps
module cycle_timer (
    input wire logic clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [2:0] base_states,
    input wire logic [2:0] extra_states,
    input wire logic sample_wait,
    input wire logic wait_n,
    output logic busy,
    output logic done,
    output logic wait_state
);
    import wait_ctl_pkg::*;

    typedef struct packed {
        logic busy;
        logic [3:0] left;
        logic sample;
        logic done;
        logic wstate;
    } timer_state_t;

    timer_state_t state_reg, state_next;

    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.wstate = 1'b0;
        if (load) begin
            state_next.busy = 1'b1;
            state_next.left = {1'b0, base_states} + {1'b0, extra_states};
            state_next.sample = sample_wait;
        end else if (state_reg.busy) begin
            if (state_reg.left > 4'h1) begin
                state_next.left = state_reg.left - 4'h1;
            end else if (state_reg.sample && !wait_n) begin
                // a low sample in the last state adds one more state
                state_next.wstate = 1'b1;
            end else begin
                state_next.busy = 1'b0;
                state_next.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign busy = state_reg.busy;
    assign done = state_reg.done;
    assign wait_state = state_reg.wstate;
endmodule

// ### src/area_wait_state_control.sv
// per-area wait state registers and bus cycle length control
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Notes on behaviour
// - read wait register is 16 bits, all ones at power-on, kept otherwise.
// - read bits 15..8 enable wait sampling for areas 7..0.
// - areas 1,3,4,5,7 external read: one state, or two plus waits.
// - areas 0,2,6 external read: one plus long wait, plus waits if enabled.
// - area 1 DRAM read column cycle: one state, or two plus waits.
// - with area 1 bit set, refresh inserts refresh wait, ignores wait input.
// - multiplexed I/O read in area 6: four states plus waits always.
// - on-chip peripheral read in area 5: three states, no sampling.
// - on-chip ROM area 0 and RAM area 7: one state, no sampling.
// - read register bits 7..2 and 0 read as one; software writes ones.
// - DRAM write column cycle: one state, or two plus waits.
// - DMA wait register is 16 bits, all ones at power-on, kept otherwise.
// - DMA read bits 15..8 enable sampling for DMA reads of areas 7..0.
// - DMA reads of areas 1,3,4,5,7: one state, or two plus waits.
// - DMA reads of areas 0,2,6: one plus long wait, plus waits if enabled.
// - DMA DRAM read column cycle: one state, or two plus waits.
// - DMA multiplexed I/O read in area 6: four states plus waits.
// - DMA write bits 7..0 time DMA writes like the DMA read bits.
// - two-bit long-wait fields for areas 0/2 and 6 give one to four states.
// - DRAM enable bit makes area 1 DRAM space.
// ---------------------------------------------------------------
module area_wait_state_control (
    input wire logic clk,
    input wire logic reset,
    input wire logic power_on_reset,
    input wire wait_ctl_pkg::reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    input wire wait_ctl_pkg::cycle_req_t cycle_req,
    input wire logic wait_n,
    output logic cycle_busy,
    output logic cycle_done,
    output logic cycle_wait_state,
    output logic [2:0] cycle_states
);
    import wait_ctl_pkg::*;

    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [15:0] read_wait;
        logic [15:0] dma_wait;
        logic [3:0] long_wait;
        logic [1:0] bus_ctl;
        logic [15:0] rdata;
        logic [2:0] states;
    } ctl_state_t;

    ctl_state_t state_reg, state_next;
    logic [2:0] base_states;
    logic [2:0] extra_states;
    logic sample_wait;
    logic area_bit;
    logic [15:0] read_view;

    // long-wait field value 0..3 means 1..4 inserted states
    function automatic logic [2:0] long_wait_states(input logic [1:0] field);
        return {1'b0, field} + 3'h1;
    endfunction

    function automatic logic wait_bit(input logic [7:0] bits, input logic [2:0] area);
        return bits[area];
    endfunction

    assign read_view = state_reg.read_wait | read_wait_fixed_ones;

    // ---------------------------------------------------------------
    // cycle length decode
    // ---------------------------------------------------------------
    always_comb begin
        base_states = st_one;
        extra_states = 3'h0;
        sample_wait = 1'b0;
        case (cycle_req.kind)
            acc_cpu_read: area_bit = wait_bit(state_reg.read_wait[rw_msb:rw_lsb], cycle_req.area);
            acc_dram_write: area_bit = state_reg.read_wait[ww1_bit];
            acc_dma_read: area_bit = wait_bit(state_reg.dma_wait[rw_msb:rw_lsb], cycle_req.area);
            acc_dma_write: area_bit = wait_bit(state_reg.dma_wait[7:0], cycle_req.area);
            acc_refresh: area_bit = state_reg.read_wait[rw_lsb + 1];
            default: area_bit = 1'b1;
        endcase
        if (cycle_req.kind == acc_refresh) begin
            if (area_bit) begin
                extra_states = {1'b0, cycle_req.refresh_wait};
            end
        end else if (cycle_req.on_chip && cycle_req.area == 3'h5 && cycle_req.kind == acc_cpu_read) begin
            base_states = st_three;
        end else if (cycle_req.on_chip && cycle_req.kind == acc_cpu_read) begin
            base_states = st_one;
        end else if (cycle_req.area == 3'h6 && state_reg.bus_ctl[0]) begin
            base_states = st_four;
            sample_wait = 1'b1;
        end else if (cycle_req.area == 3'h1 && state_reg.bus_ctl[1]) begin
            // dram column cycle: short pitch or long pitch
            base_states = area_bit ? st_two : st_one;
            sample_wait = area_bit;
        end else if (cycle_req.area == 3'h0 || cycle_req.area == 3'h2) begin
            extra_states = long_wait_states(state_reg.long_wait[3:2]);
            sample_wait = area_bit;
        end else if (cycle_req.area == 3'h6) begin
            extra_states = long_wait_states(state_reg.long_wait[1:0]);
            sample_wait = area_bit;
        end else begin
            base_states = area_bit ? st_two : st_one;
            sample_wait = area_bit;
        end
    end

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.rdata = 16'h0000;
        if (cycle_req.start) begin
            state_next.states = base_states + extra_states;
        end
        if (reg_req.wr) begin
            case (reg_req.addr)
                reg_read_wait: begin
                    // fixed-one bits ignore what is written
                    state_next.read_wait = (reg_req.wdata & read_wait_writable) | read_wait_fixed_ones;
                end
                reg_dma_wait: state_next.dma_wait = reg_req.wdata;
                reg_long_wait: state_next.long_wait = reg_req.wdata[a02_lw_lsb + 1:a6_lw_lsb];
                reg_bus_ctl: state_next.bus_ctl = {reg_req.wdata[dram_en_bit], reg_req.wdata[mux_io_bit]};
                default: state_next.bus_ctl = state_reg.bus_ctl;
            endcase
        end
        if (reg_req.rd) begin
            case (reg_req.addr)
                reg_read_wait: state_next.rdata = read_view;
                reg_dma_wait: state_next.rdata = state_reg.dma_wait;
                reg_long_wait: state_next.rdata = {1'b0, state_reg.long_wait, 11'h000};
                reg_bus_ctl: state_next.rdata = {state_reg.bus_ctl, 14'h0000};
                default: state_next.rdata = 16'h0000;
            endcase
        end
    end

    // the async reset is power-on only; manual reset and standby leave settings alone
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg.read_wait <= read_wait_reset;
            state_reg.dma_wait <= dma_wait_reset;
            state_reg.long_wait <= long_wait_reset;
            state_reg.bus_ctl <= 2'h0;
            state_reg.rdata <= 16'h0000;
            state_reg.states <= 3'h0;
        end else if (power_on_reset) begin
            state_reg.read_wait <= read_wait_reset;
            state_reg.dma_wait <= dma_wait_reset;
            state_reg.long_wait <= long_wait_reset;
            state_reg.bus_ctl <= 2'h0;
            state_reg.rdata <= 16'h0000;
            state_reg.states <= 3'h0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ---------------------------------------------------------------
    // state counter
    // ---------------------------------------------------------------
    cycle_timer timer (
        .clk(clk),
        .reset(reset),
        .load(cycle_req.start),
        .base_states(base_states),
        .extra_states(extra_states),
        .sample_wait(sample_wait),
        .wait_n(wait_n),
        .busy(cycle_busy),
        .done(cycle_done),
        .wait_state(cycle_wait_state)
    );

    assign reg_rdata = state_reg.rdata;
    assign cycle_states = state_reg.states;
endmodule

// ### tb/area_wait_props.sv
// port checker for the area wait state controller
`timescale 1ns/100ps
module area_wait_props (
    input wire logic clk,
    input wire logic reset,
    input wire logic power_on_reset,
    input wire wait_ctl_pkg::reg_req_t reg_req,
    input wire logic [15:0] reg_rdata,
    input wire wait_ctl_pkg::cycle_req_t cycle_req,
    input wire logic wait_n,
    input wire logic cycle_busy,
    input wire logic cycle_done,
    input wire logic cycle_wait_state,
    input wire logic [2:0] cycle_states
);
    import wait_ctl_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    fixed_ones_a: assert property (
        reg_req.rd && reg_req.addr == reg_read_wait |=> reg_rdata[7:2] == 6'h3f && reg_rdata[0]) else $error("fixed bits low");
    read_por_a: assert property (
        power_on_reset ##1 (reg_req.rd && reg_req.addr == reg_read_wait) |=> reg_rdata == read_wait_reset) else $error("read init");
    dma_por_a: assert property (
        power_on_reset ##1 (reg_req.rd && reg_req.addr == reg_dma_wait) |=> reg_rdata == dma_wait_reset) else $error("dma init");
    periph_states_a: assert property (
        cycle_req.start && cycle_req.on_chip && cycle_req.area == 3'h5 |=> cycle_states == st_three) else $error("periph len");
    rom_ram_states_a: assert property (
        cycle_req.start && cycle_req.on_chip && (cycle_req.area == 3'h0 || cycle_req.area == 3'h7)
        |=> cycle_states == st_one) else $error("ram len");
    busy_start_a: assert property (
        cycle_req.start |=> cycle_busy) else $error("busy not raised");
    onchip_nowait_a: assert property (
        cycle_req.start && cycle_req.on_chip |=> !cycle_wait_state [*4]) else $error("on-chip wait");
    refresh_nowait_a: assert property (
        cycle_req.start && cycle_req.kind == acc_refresh |=> !cycle_wait_state [*6]) else $error("refresh wait");
    done_bound_a: assert property (
        cycle_req.start |-> ##[2:30] cycle_done) else $error("cycle never ends");
    wait_cause_a: assert property (
        cycle_wait_state |-> !wait_n || !$past(wait_n)) else $error("wait state without low input");
endmodule
bind area_wait_state_control area_wait_props props_i (.clk(clk), .reset(reset), .power_on_reset(power_on_reset),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .cycle_req(cycle_req), .wait_n(wait_n), .cycle_busy(cycle_busy),
    .cycle_done(cycle_done), .cycle_wait_state(cycle_wait_state), .cycle_states(cycle_states));

// ### tb/wait_responder.sv
// slow memory stand-in: holds the wait input low for a set number of wait states
`timescale 1ns/100ps
module wait_responder (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] stall,
    input wire logic cycle_busy,
    input wire logic cycle_done,
    input wire logic cycle_wait_state,
    output logic wait_n
);
    logic [3:0] pending_reg;
    // pulled-up line: reads high whenever the memory lets go between cycles
    assign wait_n = !(cycle_busy && pending_reg > {3'h0, cycle_wait_state});
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pending_reg <= 4'h0;
        end else if (!cycle_busy || cycle_done) begin
            pending_reg <= stall;
        end else if (cycle_wait_state && pending_reg != 4'h0) begin
            pending_reg <= pending_reg - 4'h1;
        end
    end
endmodule

// ### tb/testbench.sv
// self-checking bench for the area wait state controller
`timescale 1ns/100ps
module testbench;
    import wait_ctl_pkg::*;
    typedef struct packed {
        access_kind_t kind;
        logic [2:0] area;
        logic on_chip;
        logic [15:0] wval, bus;
        logic [1:0] rf;
        logic [3:0] stall;
        logic [2:0] states;
        logic [3:0] waits;
    } case_t;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic power_on_reset = 1'b0;
    reg_req_t reg_req = '0;
    cycle_req_t cycle_req = '0;
    logic [3:0] stall = 4'h0;
    logic [15:0] reg_rdata;
    logic wait_n, cycle_busy, cycle_done, cycle_wait_state;
    logic [2:0] cycle_states;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    // long wait set to four states for areas 0/2 and one for area 6
    case_t tbl [16] = '{
        '{acc_cpu_read, 3'h3, 1'b0, 16'hffff, 16'h0000, 2'h0, 4'h2, 3'h2, 4'h2},
        '{acc_cpu_read, 3'h3, 1'b0, 16'hf7ff, 16'h0000, 2'h0, 4'h2, 3'h1, 4'h0},
        '{acc_cpu_read, 3'h0, 1'b0, 16'hffff, 16'h0000, 2'h0, 4'h1, 3'h5, 4'h1},
        '{acc_cpu_read, 3'h6, 1'b0, 16'hbfff, 16'h0000, 2'h0, 4'h2, 3'h2, 4'h0},
        '{acc_cpu_read, 3'h1, 1'b0, 16'hffff, 16'h8000, 2'h0, 4'h1, 3'h2, 4'h1},
        '{acc_refresh, 3'h1, 1'b0, 16'hffff, 16'h8000, 2'h2, 4'h2, 3'h3, 4'h0},
        '{acc_cpu_read, 3'h6, 1'b0, 16'hbfff, 16'h4000, 2'h0, 4'h2, 3'h4, 4'h2},
        '{acc_cpu_read, 3'h5, 1'b1, 16'hffff, 16'h0000, 2'h0, 4'h2, 3'h3, 4'h0},
        '{acc_cpu_read, 3'h7, 1'b1, 16'hffff, 16'h0000, 2'h0, 4'h2, 3'h1, 4'h0},
        '{acc_cpu_read, 3'h0, 1'b1, 16'hffff, 16'h0000, 2'h0, 4'h2, 3'h1, 4'h0},
        '{acc_dram_write, 3'h1, 1'b0, 16'hfffd, 16'h8000, 2'h0, 4'h1, 3'h1, 4'h0},
        '{acc_dma_read, 3'h4, 1'b0, 16'hefff, 16'h0000, 2'h0, 4'h1, 3'h1, 4'h0},
        '{acc_dma_read, 3'h2, 1'b0, 16'hffff, 16'h0000, 2'h0, 4'h1, 3'h5, 4'h1},
        '{acc_dma_read, 3'h6, 1'b0, 16'hbfff, 16'h4000, 2'h0, 4'h1, 3'h4, 4'h1},
        '{acc_dma_read, 3'h1, 1'b0, 16'hfdff, 16'h8000, 2'h0, 4'h2, 3'h1, 4'h0},
        '{acc_dma_write, 3'h3, 1'b0, 16'hfff7, 16'h0000, 2'h0, 4'h2, 3'h1, 4'h0}};
    area_wait_state_control DUT (.clk(clk), .reset(reset), .power_on_reset(power_on_reset), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .cycle_req(cycle_req), .wait_n(wait_n), .cycle_busy(cycle_busy),
        .cycle_done(cycle_done), .cycle_wait_state(cycle_wait_state), .cycle_states(cycle_states));
    wait_responder mem (.clk(clk), .reset(reset), .stall(stall), .cycle_busy(cycle_busy), .cycle_done(cycle_done),
        .cycle_wait_state(cycle_wait_state), .wait_n(wait_n));
    always #50 clk = ~clk;
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            summarize();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // strobe is left up; the next access overwrites the whole request
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
    endtask
    task automatic rd_check(input logic [1:0] a, input logic [15:0] exp);
        reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        reg_req <= '0;
        @(negedge clk);
        check(reg_rdata, exp);
        @(posedge clk);
    endtask
    // edges after the start edge up to the one that raises done: states plus waits
    task automatic run(input case_t c);
        int n;
        n = 0;
        // dram write bit goes back to one before area 1 may leave dram space
        wr(reg_read_wait, 16'hffff);
        wr(reg_bus_ctl, c.bus);
        wr(c.kind inside {acc_dma_read, acc_dma_write} ? reg_dma_wait : reg_read_wait, c.wval);
        cycle_req <= '{start: 1'b1, kind: c.kind, area: c.area, on_chip: c.on_chip, refresh_wait: c.rf};
        reg_req <= '0;
        stall <= c.stall;
        @(posedge clk);
        cycle_req.start <= 1'b0;
        while (n < 40) begin
            @(posedge clk);
            n++;
            @(negedge clk);
            if (cycle_done === 1'b1) break;
        end
        check(16'(n), 16'(c.states) + 16'(c.waits));
        check({15'h0000, cycle_busy}, 16'h0000);
        check({13'h0000, cycle_states}, {13'h0000, c.states});
        @(posedge clk);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd_check(reg_read_wait, read_wait_reset);
        rd_check(reg_dma_wait, dma_wait_reset);
        wr(reg_read_wait, 16'h00ff);
        rd_check(reg_read_wait, 16'h00ff);
        wr(reg_dma_wait, 16'h1234);
        rd_check(reg_dma_wait, 16'h1234);
        power_on_reset <= 1'b1;
        @(posedge clk);
        power_on_reset <= 1'b0;
        rd_check(reg_read_wait, read_wait_reset);
        power_on_reset <= 1'b1;
        @(posedge clk);
        power_on_reset <= 1'b0;
        rd_check(reg_dma_wait, dma_wait_reset);
        wr(reg_long_wait, 16'h6000);
        foreach (tbl[i]) run(tbl[i]);
        summarize();
    end
endmodule
